// ### design/serial_in_parallel_out_expander.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE1] Ten stages load serially, all show in parallel, the last drives serial out.
// [RULE2] Each low-to-high shift clock edge shifts once and captures serial data in.
// [RULE3] Enable high shows the stages, enable low forces parallel outputs to zero and keeps data.
// [RULE4] Serial out follows the last stage regardless of enable.
// [RULE5] Serial out feeds the next device serial in, so chains grow in tens.
// [RULE6] Reset clears all stages to zero before any shift clock.
// [RULE7] The host never holds one shift clock pulse longer than ten milliseconds.
// [RULE8] The host keeps the shift clock low and high for at least six microseconds each.
// [RULE9] Data may change with the rising shift clock; the clock is delayed to capture it.
// [RULE10] The host writes data, then clock high with enable, then clock low with enable; the host model writes data together with clock high.
// [RULE11] Bits enter stage zero and move toward stage nine, which drives serial out.
module serial_in_parallel_out_expander
  import sipo_expander_pkg::*;
#(
  parameter int STAGES = STAGE_COUNT,
  parameter int DELAY_CYCLES = CLOCK_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Host pins
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic output_enable,
  // Outputs
  output logic [STAGES-1:0] parallel_out,
  output logic serial_out
);
  logic clk_s;
  logic data_s;
  logic en_s;
  logic [STAGES-1:0] stages_ff;
  logic [STAGES-1:0] nxt_stages;
  logic [STAGES-1:0] par_ff;
  logic [STAGES-1:0] nxt_par;
  logic ser_ff;
  logic nxt_ser;
  edge_state_t state_ff;
  edge_state_t nxt_state;
  logic [7:0] dly_ff;
  logic [7:0] nxt_dly;
  logic shift_now;

  //////////////////////////////////////////////////////////////////////
  // Shift helper, shared by the datapath and its check
  function automatic logic [STAGES-1:0] shift_in(input logic [STAGES-1:0] cur,
                                                 input logic bit_in);
    // Newest bit enters stage zero, oldest falls out of the top
    return {cur[STAGES-2:0], bit_in};
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin_in({shift_clock, serial_in, output_enable}),
    .pin_sync_out({clk_s, data_s, en_s})
  );

  //////////////////////////////////////////////////////////////////////
  // Rising edge detect with delayed capture
  always_comb begin
    nxt_state = state_ff;
    nxt_dly = dly_ff;
    shift_now = 1'b0;
    unique case (state_ff)
      WAIT_LOW: begin
        nxt_dly = 8'h00;
        if (!clk_s) begin
          nxt_state = WAIT_HIGH;
        end
      end
      WAIT_HIGH: begin
        if (clk_s) begin
          // Wait past the edge so simultaneous data settles
          if (dly_ff >= 8'(DELAY_CYCLES)) begin // see [RULE9]
            shift_now = 1'b1; // see [RULE2]
            nxt_state = WAIT_LOW;
          end else begin
            nxt_dly = dly_ff + 8'h01;
          end
        end else begin
          nxt_dly = 8'h00;
        end
      end
      default: begin
        nxt_state = WAIT_LOW;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // Shift register and outputs
  always_comb begin
    nxt_stages = stages_ff;
    if (shift_now) begin
      nxt_stages = shift_in(stages_ff, data_s); // see [RULE11] see [RULE1]
    end
    nxt_par = en_s ? nxt_stages : '0; // see [RULE3]
    nxt_ser = nxt_stages[STAGES-1]; // see [RULE4] see [RULE5]
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      // Power-on clear, starts in WAIT_LOW so a high clock at reset is no edge
      stages_ff <= '0; // see [RULE6]
      par_ff <= '0;
      ser_ff <= 1'b0;
      state_ff <= WAIT_LOW;
      dly_ff <= 8'h00;
    end else begin
      stages_ff <= nxt_stages;
      par_ff <= nxt_par;
      ser_ff <= nxt_ser;
      state_ff <= nxt_state;
      dly_ff <= nxt_dly;
    end
  end

  assign parallel_out = par_ff;
  assign serial_out = ser_ff;

  //////////////////////////////////////////////////////////////////////
  // Checks
  a_shift_moves_data: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now |=> stages_ff == shift_in($past(stages_ff), $past(data_s))) // see [RULE2]
    else $error("shift did not move data");
  a_hold_no_shift: assert property (@(posedge mclk) disable iff (!reset_n)
    !shift_now |=> $stable(stages_ff)) // see [RULE3]
    else $error("stages changed without shift");
  a_disable_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    !en_s |=> parallel_out == '0) // see [RULE3]
    else $error("parallel out not zero when disabled");
  a_enable_shows: assert property (@(posedge mclk) disable iff (!reset_n)
    en_s |=> parallel_out == stages_ff) // see [RULE1]
    else $error("parallel out does not match stages");
  a_serial_tracks: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 serial_out == stages_ff[STAGES-1]) // see [RULE4]
    else $error("serial out not last stage");
  a_reset_clears: assert property (@(posedge mclk)
    !reset_n |=> stages_ff == '0 && parallel_out == '0 && !serial_out) // see [RULE6]
    else $error("reset did not clear");
  a_one_shift_per_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now |=> !shift_now) // see [RULE2]
    else $error("double shift on one pulse");
  a_delayed_capture: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now |-> clk_s && $past(clk_s)) // see [RULE9]
    else $error("capture not delayed after edge");

  // Edge tracker always holds exactly one state
  a_state_onehot: assert property (@(posedge mclk) disable iff (!reset_n)
    $onehot(state_ff)) // see [RULE2]
    else $error("edge tracker state not one-hot");

  // A low clock level never shifts
  a_low_no_shift: assert property (@(posedge mclk) disable iff (!reset_n)
    !clk_s |-> !shift_now) // see [RULE2]
    else $error("shift while clock low");

  // After a shift the tracker must see a low level first
  a_wait_low_first: assert property (@(posedge mclk) disable iff (!reset_n)
    state_ff == WAIT_LOW |-> !shift_now) // see [RULE2]
    else $error("shift without a fresh rising edge");

  // Capture only once the full internal delay has passed
  a_shift_needs_count: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now |-> dly_ff >= 8'(DELAY_CYCLES)) // see [RULE9]
    else $error("capture before delay elapsed");

  // Delay counter never runs past its target
  a_dly_bounded: assert property (@(posedge mclk) disable iff (!reset_n)
    dly_ff <= 8'(DELAY_CYCLES)) // see [RULE9]
    else $error("delay counter overran");

  // New bit appears on output zero when enabled
  a_par_newest_bit: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now && en_s |=> parallel_out[0] == $past(data_s)) // see [RULE11]
    else $error("new bit not on output zero");

  // Serial out takes the stage just below the top on a shift
  a_ser_after_shift: assert property (@(posedge mclk) disable iff (!reset_n)
    shift_now |=> serial_out == $past(stages_ff[STAGES-2])) // see [RULE11]
    else $error("serial out did not advance");

  // Disabled outputs do not touch the stored word
  a_keep_disabled: assert property (@(posedge mclk) disable iff (!reset_n)
    !en_s && !shift_now |=> stages_ff == $past(stages_ff)) // see [RULE3]
    else $error("stages changed while disabled");

  // Serial out keeps following the top stage while disabled
  a_ser_ignores_en: assert property (@(posedge mclk) disable iff (!reset_n)
    !en_s |=> serial_out == stages_ff[STAGES-1]) // see [RULE4]
    else $error("serial out gated by enable");

  // Reset puts the tracker back to waiting for low
  a_reset_state: assert property (@(posedge mclk)
    !reset_n |=> state_ff == WAIT_LOW) // see [RULE6]
    else $error("reset did not restart edge tracker");

  // Reset clears the delay counter
  a_reset_dly: assert property (@(posedge mclk)
    !reset_n |=> dly_ff == 8'h00) // see [RULE6]
    else $error("reset did not clear delay counter");
endmodule
`default_nettype wire

// ### design/sipo_expander_pkg.sv
package sipo_expander_pkg;
  // Register geometry
  localparam int STAGE_COUNT = 10;
  localparam logic [9:0] STAGES_RESET = 10'h000;
  // Clock period in ns
  localparam int MCLK_PERIOD_NS = 50;
  // Internal delay of the shift clock edge, in ns, and in cycles
  localparam int CLOCK_DELAY_NS = 100;
  localparam int CLOCK_DELAY_CYCLES =
    (CLOCK_DELAY_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  // Edge detector states
  typedef enum logic [1:0] {
    WAIT_LOW  = 2'b01,
    WAIT_HIGH = 2'b10
  } edge_state_t;
endpackage

// ### design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Pins in and synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;

  // Two-stage chain; first stage feeds only the second
  always_comb begin
    nxt_meta = pin_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign pin_sync_out = sync_ff;
endmodule
`default_nettype wire

// ### bench/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // Clock
  input wire logic mclk,
  // Port lines
  output logic shift_clock,
  output logic serial_in,
  output logic output_enable
);
  // Lines idle low
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    output_enable = 1'b0;
  end
  // One bit: data and clock high with enable, then clock low with enable
  task automatic send(input logic d, input logic en);
    @(posedge mclk);
    serial_in <= d;
    shift_clock <= 1'b1;
    output_enable <= en;
    repeat (120) @(posedge mclk);
    shift_clock <= 1'b0;
    repeat (120) @(posedge mclk);
  endtask
  // Enable alone, clock left low
  task automatic set_enable(input logic en);
    @(posedge mclk);
    output_enable <= en;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sipo_expander_pkg::*;
  typedef struct packed {logic [9:0] pat; logic en; logic [9:0] exp;} row_t;
  localparam row_t ROWS [3] = '{'{10'h3A5, 1'b1, 10'h3A5}, '{10'h35A, 1'b0, 10'h000},
    '{10'h0C3, 1'b1, 10'h0C3}};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic shift_clock, serial_in, output_enable, serial_out;
  logic [STAGE_COUNT-1:0] parallel_out;
  int error_cnt = 0;
  int num_checks = 0;
  always #25 mclk = ~mclk;
  host_port_model host_port_model_inst (.mclk(mclk), .shift_clock(shift_clock),
    .serial_in(serial_in), .output_enable(output_enable));
  serial_in_parallel_out_expander serial_in_parallel_out_expander_inst (.mclk(mclk),
    .reset_n(reset_n), .shift_clock(shift_clock), .serial_in(serial_in),
    .output_enable(output_enable), .parallel_out(parallel_out), .serial_out(serial_out));
  // Compare and count
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Table rows, then mid-run reset
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int r = 0; r < 3; r++) begin
      for (int i = 9; i >= 0; i--) host_port_model_inst.send(ROWS[r].pat[i], ROWS[r].en);
      check("parallel_out", parallel_out, ROWS[r].exp);
      check("serial_out", {9'h000, serial_out}, {9'h000, ROWS[r].pat[9]});
      $display("row %0d done", r);
    end
    host_port_model_inst.send(1'b1, 1'b1);
    check("parallel_out", parallel_out, 10'h187);
    check("serial_out", {9'h000, serial_out}, 10'h000);
    host_port_model_inst.set_enable(1'b0);
    check("parallel_out", parallel_out, 10'h000);
    host_port_model_inst.set_enable(1'b1);
    check("parallel_out", parallel_out, 10'h187);
    $display("enable test done");
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    check("parallel_out", parallel_out, 10'h000);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    host_port_model_inst.send(1'b1, 1'b1);
    check("parallel_out", parallel_out, 10'h001);
    $display("reset test done");
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
